// *** rtl/etr_pkg.sv ***
// Purpose: Shared constants and types for the trim and block_reset_control block
// Assumes: APB byte addresses are four times the register index
// Notes:   Register indices are kept as printed; see etr_regs for use

package etr_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned    ADDR_W       = 10;
  localparam logic [7:0]     IDX_EEPROM   = 8'h18;
  localparam logic [7:0]     IDX_TRIM     = 8'h19;
  localparam logic [7:0]     IDX_RESET    = 8'h1B;
  localparam logic [7:0]     IDX_VARIANT  = 8'h1F;
  localparam logic [ADDR_W-1:0] ADDR_EEPROM  = {IDX_EEPROM, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_TRIM    = {IDX_TRIM, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RESET   = {IDX_RESET, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_VARIANT = {IDX_VARIANT, 2'h0};

  // ==========================================================================
  // Field positions
  localparam int unsigned    SER_DATA_BIT = 7;
  localparam int unsigned    SER_CLK_BIT  = 0;
  localparam int unsigned    RST_QUEUE    = 0;
  localparam int unsigned    RST_TRIM     = 1;
  localparam int unsigned    RST_PORT     = 2;
  localparam int unsigned    RST_OUT      = 3;
  localparam int unsigned    RST_GLOBAL   = 4;
  localparam int unsigned    VAR_A_BIT    = 0;
  localparam int unsigned    VAR_E_BIT    = 1;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0]     EE_PORT_RST  = 8'h00;
  localparam logic [7:0]     POT_RST      = 8'h80;
  localparam logic [3:0]     POT_LAST_BIT = 4'h9;
  localparam int unsigned    POT_COUNT    = 4;

  // ==========================================================================
  // Types
  typedef logic [7:0] etr_byte_t;
  typedef etr_byte_t [POT_COUNT-1:0] etr_pot_bank_t;

  typedef struct packed {
    logic global_clear;
    logic output_converter_zero;
    logic parallel_port_clear;
    logic trim_pot_clear;
    logic sample_queue_clear;
  } etr_clear_s;

  typedef enum logic [1:0] {
    POT_IDLE,
    POT_SHIFT,
    POT_DONE
  } etr_pot_state_e;

endpackage

// *** rtl/etr_pot_loader.sv ***
// Purpose: Serial loader for the four 8-bit trim potentiometers
// Assumes: One write strobe per port write; bit 0 set marks a shift
// Notes:   Frame is enable, 2 address bits, 8 value bits, end byte

`timescale 1ns/1ps

module etr_pot_loader
  import etr_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          wr_stb,
  input  wire etr_byte_t     wr_data,
  input  wire logic          pot_clear,
  output etr_pot_bank_t      pot_setting
);

  etr_pot_state_e state_reg;
  logic [9:0]     shift_reg;
  logic [3:0]     cnt_reg;
  etr_pot_bank_t  pot_bank_reg;
  logic           is_enable;
  logic           is_shift;

  assign is_enable   = wr_data[SER_DATA_BIT] & ~wr_data[SER_CLK_BIT];
  assign is_shift    = wr_data[SER_CLK_BIT];
  assign pot_setting = pot_bank_reg;

  // ==========================================================================
  // Frame sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= POT_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 10'h000;
    end else if (pot_clear) begin
      state_reg <= POT_IDLE;
      cnt_reg   <= 4'h0;
    end else if (wr_stb) begin
      unique case (state_reg)
        POT_IDLE: begin
          if (is_enable) begin
            state_reg <= POT_SHIFT;
            cnt_reg   <= 4'h0;
          end
        end
        POT_SHIFT: begin
          if (is_shift) begin
            shift_reg <= {shift_reg[8:0], wr_data[SER_DATA_BIT]};
            cnt_reg   <= cnt_reg + 4'h1;
            if (cnt_reg == POT_LAST_BIT) begin
              state_reg <= POT_DONE;
            end
          end else if (is_enable) begin
            cnt_reg <= 4'h0;
          end else begin
            // A low-clock byte with bit 7 clear aborts the frame
            state_reg <= POT_IDLE;
          end
        end
        POT_DONE: begin
          // Any end byte commits; an enable byte also opens a new frame
          state_reg <= is_enable ? POT_SHIFT : POT_IDLE;
          cnt_reg   <= 4'h0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Settings, committed whole so a partial frame never shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pot_bank_reg <= {POT_COUNT{POT_RST}};
    end else if (pot_clear) begin
      pot_bank_reg <= {POT_COUNT{POT_RST}};
    end else if (wr_stb && state_reg == POT_DONE) begin
      pot_bank_reg[shift_reg[9:8]] <= shift_reg[7:0];
    end
  end

  // ==========================================================================
  // Checks
  sequence s_end_byte;
    wr_stb && !pot_clear && state_reg == POT_DONE;
  endsequence

  property p_commit;
    @(posedge pclk) disable iff (!presetn)
    s_end_byte |=> pot_bank_reg[$past(shift_reg[9:8])] ==
                   $past(shift_reg[7:0]);
  endproperty
  a_commit: assert property (p_commit)
    else $error("pot value not committed at end byte");

  property p_shift;
    @(posedge pclk) disable iff (!presetn)
    (wr_stb && !pot_clear && state_reg == POT_SHIFT && is_shift) |=>
      shift_reg[0] == $past(wr_data[SER_DATA_BIT]) &&
      shift_reg[9:1] == $past(shift_reg[8:0]);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit not shifted in");

  property p_select;
    @(posedge pclk) disable iff (!presetn)
    (s_end_byte and (shift_reg[9:8] == 2'h0)) |=>
      pot_bank_reg[3:1] == $past(pot_bank_reg[3:1]);
  endproperty
  a_select: assert property (p_select)
    else $error("address 0 frame touched another pot");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    pot_clear |=> pot_bank_reg == {POT_COUNT{POT_RST}} &&
                  state_reg == POT_IDLE;
  endproperty
  a_clear: assert property (p_clear)
    else $error("pot clear did not restore settings");

endmodule

// *** rtl/etr_regs.sv ***
// Purpose: APB register block for EEPROM port, trim pots, resets, variant
// Assumes: Zero-wait APB slave; software paces every serial step
// Notes:   EEPROM data input is an external pin and is synchronised
//
// Function
// - EEPROM port: bit7 data, bit0 clock
// - Sixteen reads return word MSB first
// - Trim pots loaded serially, bit7 data
// - Two-bit address selects one of four pots
// - Each pot holds full eight-bit value
// - Reset bits clear their matching unit
// - Output reset zeroes both output converters
// - Bit 4 clears everything plus configuration
// - Variant register shows model in bits 1:0
//
// Added by the designer: the APB slave port.

`timescale 1ns/1ps

module etr_regs
  import etr_pkg::*;
#(
  parameter logic VARIANT_E = 1'b0
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   ee_data_out,
  output logic                   ee_sclk_out,
  input  wire logic              ee_data_in,
  output etr_clear_s             unit_clear,
  output logic [15:0]            dac0_code,
  output logic [15:0]            dac1_code,
  output etr_pot_bank_t          pot_setting
);

  // ==========================================================================
  // Bus decode
  logic       setup_ph;
  logic       wr_acc;
  logic       lane0;
  logic       hit_ee;
  logic       hit_trim;
  logic       hit_rst;
  logic       hit_var;
  logic       mapped;
  etr_byte_t  wbyte;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  // Only byte lane 0 carries data; a write without it stores nothing
  assign lane0    = pstrb[0];
  assign wbyte    = pwdata[7:0];
  assign hit_ee   = paddr == ADDR_EEPROM;
  assign hit_trim = paddr == ADDR_TRIM;
  assign hit_rst  = paddr == ADDR_RESET;
  assign hit_var  = paddr == ADDR_VARIANT;
  assign mapped   = hit_ee | hit_trim | hit_rst | hit_var;

  // Never stalls: every access completes in its first access cycle
  assign pready   = 1'b1;

  // ==========================================================================
  // EEPROM data input synchroniser
  logic ee_in_meta_reg;
  logic ee_in_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_in_meta_reg <= 1'b0;
      ee_in_sync_reg <= 1'b0;
    end else begin
      ee_in_meta_reg <= ee_data_in;
      ee_in_sync_reg <= ee_in_meta_reg;
    end
  end

  // ==========================================================================
  // Block_reset_control pulses
  etr_clear_s clear_reg;
  etr_byte_t  rst_bits;
  logic       rst_wr;

  assign rst_wr   = wr_acc & hit_rst & lane0;
  assign rst_bits = rst_wr ? wbyte : 8'h00;

  // Held for one cycle only, so a later zero write changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_reg <= '0;
    end else begin
      clear_reg.global_clear          <= rst_bits[RST_GLOBAL];
      clear_reg.output_converter_zero <= rst_bits[RST_OUT] |
                                         rst_bits[RST_GLOBAL];
      clear_reg.parallel_port_clear   <= rst_bits[RST_PORT] |
                                         rst_bits[RST_GLOBAL];
      clear_reg.trim_pot_clear        <= rst_bits[RST_TRIM] |
                                         rst_bits[RST_GLOBAL];
      clear_reg.sample_queue_clear    <= rst_bits[RST_QUEUE] |
                                         rst_bits[RST_GLOBAL];
    end
  end

  assign unit_clear = clear_reg;

  // ==========================================================================
  // Output converter codes; only the clear path acts on them here
  logic [15:0] dac0_reg;
  logic [15:0] dac1_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac0_reg <= 16'h0000;
      dac1_reg <= 16'h0000;
    end else if (clear_reg.output_converter_zero) begin
      dac0_reg <= 16'h0000;
      dac1_reg <= 16'h0000;
    end
  end

  assign dac0_code = dac0_reg;
  assign dac1_code = dac1_reg;

  // ==========================================================================
  // EEPROM serial port
  etr_byte_t ee_port_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_port_reg <= EE_PORT_RST;
    end else if (clear_reg.global_clear) begin
      ee_port_reg <= EE_PORT_RST;
    end else if (wr_acc && hit_ee && lane0) begin
      // Software sequences the protocol itself by these writes
      ee_port_reg <= wbyte;
    end
  end

  assign ee_data_out = ee_port_reg[SER_DATA_BIT];
  assign ee_sclk_out = ee_port_reg[SER_CLK_BIT];

  // ==========================================================================
  // Trim potentiometer loader
  logic trim_wr;

  assign trim_wr = wr_acc & hit_trim & lane0;

  etr_pot_loader u_pot_loader (
    .pclk        (pclk),
    .presetn     (presetn),
    .wr_stb      (trim_wr),
    .wr_data     (wbyte),
    .pot_clear   (clear_reg.trim_pot_clear),
    .pot_setting (pot_setting)
  );

  // ==========================================================================
  // Read data and error, captured in the setup cycle
  etr_byte_t variant_val;
  etr_byte_t rd_byte;
  logic [31:0] prdata_reg;
  logic        slverr_reg;

  always_comb begin
    variant_val            = 8'h00;
    variant_val[VAR_A_BIT] = ~VARIANT_E;
    variant_val[VAR_E_BIT] = VARIANT_E;
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit_ee) begin
      rd_byte[SER_DATA_BIT] = ee_in_sync_reg;
    end else if (hit_var) begin
      rd_byte = variant_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slverr_reg <= 1'b0;
    end else if (setup_ph) begin
      slverr_reg <= ~mapped;
    end else if (!psel) begin
      slverr_reg <= 1'b0;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = slverr_reg;

  // ==========================================================================
  // Checks
  sequence s_rst_write(int unsigned b);
    wr_acc && hit_rst && lane0 && pwdata[b];
  endsequence

  property p_ee_pins;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_ee && lane0 && !clear_reg.global_clear) |=>
      ee_data_out == $past(pwdata[7]) && ee_sclk_out == $past(pwdata[0]);
  endproperty
  a_ee_pins: assert property (p_ee_pins)
    else $error("EEPROM port pins do not follow write");

  property p_ee_read;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_ee) |=>
      prdata[7] == $past(ee_in_sync_reg) && prdata[6:0] == 7'h00;
  endproperty
  a_ee_read: assert property (p_ee_read)
    else $error("EEPROM read bit not returned in bit 7");

  property p_unit_clear;
    @(posedge pclk) disable iff (!presetn)
    s_rst_write(RST_PORT) |=> clear_reg.parallel_port_clear;
  endproperty
  a_unit_clear: assert property (p_unit_clear)
    else $error("port clear bit gave no pulse");

  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
    (s_rst_write(RST_QUEUE) ##1 !rst_wr) |=> !clear_reg.sample_queue_clear;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("clear pulse lasted more than one cycle");

  property p_zero_write;
    @(posedge pclk) disable iff (!presetn)
    (rst_wr && pwdata[4:0] == 5'h00) |=> clear_reg == '0;
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("zero write produced a clear");

  property p_dac_zero;
    @(posedge pclk) disable iff (!presetn)
    s_rst_write(RST_OUT) |=> ##1 dac0_code == 16'h0000 &&
                                 dac1_code == 16'h0000;
  endproperty
  a_dac_zero: assert property (p_dac_zero)
    else $error("output converters not zeroed");

  property p_global;
    @(posedge pclk) disable iff (!presetn)
    s_rst_write(RST_GLOBAL) |=> clear_reg == '1 ##1
      (ee_port_reg == EE_PORT_RST && pot_setting == {POT_COUNT{POT_RST}});
  endproperty
  a_global: assert property (p_global)
    else $error("global clear incomplete");

  property p_variant;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_var) |=>
      prdata == {30'h0000_0000, VARIANT_E, ~VARIANT_E};
  endproperty
  a_variant: assert property (p_variant)
    else $error("variant register value wrong");

endmodule

// *** dv/etr_regs_tb.sv ***
// Purpose: Self-checking bench for the EEPROM, trim and reset registers
// Assumes: Zero-wait APB slave; pready is sampled at every access edge
// Notes:   Random values from a fixed seed; the long EEPROM busy wait
//          after a read is not modelled, nothing touches the port after

`timescale 1ns/1ps

module tb
  import etr_pkg::*;
;
  localparam logic VE  = 1'b1;
  // Host gap between EEPROM accesses, 4 us at 25 ns
  localparam int   GAP = 160;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              ee_data_out;
  logic              ee_sclk_out;
  logic              ee_data_in;
  etr_clear_s        unit_clear;
  logic [15:0]       dac0_code;
  logic [15:0]       dac1_code;
  etr_pot_bank_t     pot_setting;
  etr_pot_bank_t     exp_pot;
  logic [31:0]       rd_tmp;
  logic              err_tmp;
  int                n_fail;
  int                checks_done;
  int unsigned       seed_word;

  etr_regs #(
    .VARIANT_E (VE)
  ) DUT (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .pstrb       (pstrb),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .ee_data_out (ee_data_out),
    .ee_sclk_out (ee_sclk_out),
    .ee_data_in  (ee_data_in),
    .unit_clear  (unit_clear),
    .dac0_code   (dac0_code),
    .dac1_code   (dac1_code),
    .pot_setting (pot_setting)
  );

  // ==========================================================================
  // Expectations
  function automatic etr_byte_t ser_byte(input logic b);
    return {b, 6'h00, 1'b1};
  endfunction

  function automatic etr_byte_t ee_byte(input int i, input logic [5:0] ad);
    case (i)
      0: return 8'h80;
      1: return 8'h81;
      2: return 8'h81;
      3: return 8'h01;
      default: return ser_byte(ad[9-i]);
    endcase
  endfunction

  // ==========================================================================
  // Compare, bus and closing tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input etr_byte_t d);
    apb(1'b1, a, {24'h000000, d}, 4'hF, rd_tmp, err_tmp);
  endtask

  task automatic rdw(input logic [ADDR_W-1:0] a);
    apb(1'b0, a, 32'h00000000, 4'h0, rd_tmp, err_tmp);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic ee_read(input logic [5:0] ad, input logic [15:0] w);
    etr_byte_t b;
    int        i;
    for (i = 0; i < 10; i++) begin
      b = ee_byte(i, ad);
      repeat (GAP) @(posedge pclk);
      wr(ADDR_EEPROM, b);
      @(negedge pclk);
      chk({ee_data_out, ee_sclk_out}, {b[7], b[0]});
    end
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      ee_data_in <= w[15-i];
      repeat (GAP) @(posedge pclk);
      rdw(ADDR_EEPROM);
      chk(rd_tmp[7], w[15-i]);
    end
    repeat (GAP) @(posedge pclk);
    wr(ADDR_EEPROM, 8'h00);
    @(negedge pclk);
    chk({ee_data_out, ee_sclk_out}, 2'b00);
  endtask

  task automatic pot_load(input logic [1:0] a, input etr_byte_t v);
    int i;
    wr(ADDR_TRIM, 8'h80);
    for (i = 0; i < 10; i++)
      wr(ADDR_TRIM, ser_byte(i < 2 ? a[1-i] : v[9-i]));
    wr(ADDR_TRIM, 8'h00);
    exp_pot[a] = v;
    repeat (2) @(negedge pclk);
    chk(pot_setting, exp_pot);
  endtask

  task automatic reset_walk();
    etr_byte_t v;
    int        cnt [5];
    int        i;
    int        j;
    int        k;
    pot_load(2'b10, 8'($urandom));
    for (i = 0; i < 6; i++) begin
      v = (i < 5) ? 8'(1 << i) : 8'h00;
      if (i == 4)
        wr(ADDR_EEPROM, 8'h80);
      wr(ADDR_RESET, v);
      cnt = '{default: 0};
      for (k = 0; k < 3; k++) begin
        @(negedge pclk);
        for (j = 0; j < 5; j++)
          cnt[j] += int'(unit_clear[j] === 1'b1);
      end
      for (j = 0; j < 5; j++)
        chk(cnt[j], (j == i || i == 4) ? 1 : 0);
      if (i == 1 || i == 4)
        exp_pot = {POT_COUNT{POT_RST}};
      chk(pot_setting, exp_pot);
      chk({dac0_code, dac1_code}, 32'h00000000);
      if (i == 4)
        chk({ee_data_out, ee_sclk_out}, 2'b00);
    end
  endtask

  // ==========================================================================
  // Clock, reset, watchdog and main sequence
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    stop_test();
  end

  initial begin
    int k;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    ee_data_in = 1'b0;
    n_fail = 0;
    checks_done = 0;
    exp_pot = {POT_COUNT{POT_RST}};
    seed_word = $urandom(1757);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({prdata, pslverr, ee_data_out, ee_sclk_out}, 35'h0);
    chk({unit_clear, dac0_code, dac1_code}, 37'h0);
    chk(pot_setting, exp_pot);
    rdw(ADDR_VARIANT);
    chk(rd_tmp, {30'h0, VE, ~VE});
    wr(ADDR_VARIANT, 8'hFF);
    rdw(ADDR_VARIANT);
    chk({err_tmp, rd_tmp}, {1'b0, 30'h0, VE, ~VE});
    rdw(10'h068);
    chk({err_tmp, rd_tmp}, {1'b1, 32'h0});
    rdw(ADDR_TRIM);
    chk(rd_tmp, 32'h0);
    rdw(ADDR_RESET);
    chk(rd_tmp, 32'h0);
    apb(1'b1, ADDR_EEPROM, 32'h00000081, 4'h0, rd_tmp, err_tmp);
    @(negedge pclk);
    chk({ee_data_out, ee_sclk_out}, 2'b00);
    pot_load(2'b01, 8'h4F);
    pot_load(2'b11, 8'hFF);
    pot_load(2'b00, 8'h00);
    for (k = 0; k < 8; k++)
      pot_load(2'(k), 8'($urandom));
    reset_walk();
    // ==========================================================================
    // Mid-run reset brings every setting back to its reset value
    pot_load(2'b11, 8'h5A);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(negedge pclk);
    exp_pot = {POT_COUNT{POT_RST}};
    chk(pot_setting, exp_pot);
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({unit_clear, ee_data_out, ee_sclk_out, prdata}, 39'h0);
    // Only one word read: the busy time after it runs past the end
    ee_read(6'h3F, 16'hA5A5 ^ 16'($urandom));
    stop_test();
  end

endmodule
